// ===== pdm_params.svh
/*
  Constants for the port D low pin-function mux: bit positions, reset
  values of the configuration set. Assumes it is included by bare name.
*/
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define PDM_PIN_DMSEL 9
`define PDM_PIN_CSTWO 0
`define PDM_SEL_CAN_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDM_PULLUP_RST 16'hFFFF
`define PDM_PERIPH_EN_RST 16'h0200
`define PDM_PERIPH_SEL_RST 16'h0000
`define PDM_BUS_DRIVE_RST 1'b0
`define PDM_DM_MODE_RST 1'b1
`define PDM_GPIO_DIR_RST 16'h0000
`define PDM_GPIO_DATA_RST 16'h0000

`endif

// ===== pdm_pkg.sv
/*
  Types for the port D low pin-function mux.
  Assumes the params header is compiled alongside.
*/
package pdm_pkg;

  // ----------------------------------------------------------------
  // pin owner
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDM_FN_GPIO = 2'b00,
    PDM_FN_CHIPSEL = 2'b01,
    PDM_FN_CAN = 2'b10
  } pdm_func_e;

endpackage : pdm_pkg

// ===== pdm_pin_cell.sv
/*
  One pad cell: registers the drive request and pull-up, and brings the
  pad level into the clock domain through two flip-flops.
  Assumes the pad wire is resolved outside from out and oe_n.
*/
`timescale 1ns/1ps

module pdm_pin_cell (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic drive_en_i,
  input wire logic drive_val_i,
  input wire logic pullup_en_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_n_o,
  output logic pad_pullup_o,
  output logic pad_sync_o
);

  logic out_reg, out_next;
  logic oe_n_reg, oe_n_next;
  logic pu_reg, pu_next;
  logic meta_reg, sync_reg;

  // ----------------------------------------------------------------
  // next values: oe_n low means the pad is driven
  // ----------------------------------------------------------------
  always_comb begin
    out_next = drive_val_i;
    oe_n_next = ~drive_en_i;
    pu_next = pullup_en_i;
  end

  // reset releases the pad with the pull-up on
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      pu_reg <= 1'b1;
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
      pu_reg <= pu_next;
      meta_reg <= pad_in_i; // only read by sync_reg
      sync_reg <= meta_reg;
    end
  end

  assign pad_out_o = out_reg;
  assign pad_oe_n_o = oe_n_reg;
  assign pad_pullup_o = pu_reg;
  assign pad_sync_o = sync_reg;

endmodule : pdm_pin_cell

// ===== pdm_port_d_mux.sv
/*
  Pin-function mux for two shared port D pins: the data memory select
  pin (port_d_pin9) and the chip_select_two / second_can_transmit pin
  (port_d_pin0). Assumes the external memory controller reports its
  access phase and address on the same clock, and that pads resolve
  from out / oe_n / pullup outside.
*/
`timescale 1ns/1ps
`include "pdm_params.svh"

module pdm_port_d_mux #(
  parameter int ADDR_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_mem_active_i,
  input wire logic ext_mem_data_space_i,
  input wire logic [ADDR_W-1:0] ext_mem_addr_i,
  input wire logic [ADDR_W-1:0] chip_select_one_base_i,
  input wire logic [ADDR_W-1:0] chip_select_one_mask_i,
  input wire logic [ADDR_W-1:0] chip_select_two_base_i,
  input wire logic [ADDR_W-1:0] chip_select_two_mask_i,
  input wire logic cfg_we_i,
  input wire logic [15:0] port_d_pullup_enable_i,
  input wire logic [15:0] port_d_peripheral_enable_i,
  input wire logic [15:0] peripheral_select_register_i,
  input wire logic bus_drive_control_i,
  input wire logic data_memory_select_mode_i,
  input wire logic [15:0] gpio_dir_i,
  input wire logic [15:0] gpio_data_i,
  input wire logic second_can_transmit_i,
  input wire logic port_d_pin9_in_i,
  input wire logic port_d_pin0_in_i,
  output logic port_d_pin9_out_o,
  output logic port_d_pin9_oe_n_o,
  output logic port_d_pin9_pullup_o,
  output logic port_d_pin0_out_o,
  output logic port_d_pin0_oe_n_o,
  output logic port_d_pin0_pullup_o,
  output logic [1:0] port_d_gpio_in_o,
  output pdm_pkg::pdm_func_e pin9_func_o,
  output pdm_pkg::pdm_func_e pin0_func_o,
  output logic data_memory_select_mode_o
);

  // ----------------------------------------------------------------
  // configuration set
  // ----------------------------------------------------------------
  logic [15:0] pullup_reg, pullup_next;
  logic [15:0] periph_en_reg, periph_en_next;
  logic [15:0] periph_sel_reg, periph_sel_next;
  logic bus_drive_reg, bus_drive_next;
  logic dm_mode_reg, dm_mode_next;
  logic [15:0] gpio_dir_reg, gpio_dir_next;
  logic [15:0] gpio_data_reg, gpio_data_next;

  // all fields load together on one strobe
  always_comb begin
    pullup_next = pullup_reg;
    periph_en_next = periph_en_reg;
    periph_sel_next = periph_sel_reg;
    bus_drive_next = bus_drive_reg;
    dm_mode_next = dm_mode_reg;
    gpio_dir_next = gpio_dir_reg;
    gpio_data_next = gpio_data_reg;
    if (cfg_we_i) begin
      pullup_next = port_d_pullup_enable_i;
      periph_en_next = port_d_peripheral_enable_i;
      periph_sel_next = peripheral_select_register_i;
      bus_drive_next = bus_drive_control_i;
      dm_mode_next = data_memory_select_mode_i;
      gpio_dir_next = gpio_dir_i;
      gpio_data_next = gpio_data_i;
    end
  end

  // reset: pin9 owned by data select, pin0 gpio, bus released when idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pullup_reg <= `PDM_PULLUP_RST;
      periph_en_reg <= `PDM_PERIPH_EN_RST;
      periph_sel_reg <= `PDM_PERIPH_SEL_RST;
      bus_drive_reg <= `PDM_BUS_DRIVE_RST;
      dm_mode_reg <= `PDM_DM_MODE_RST;
      gpio_dir_reg <= `PDM_GPIO_DIR_RST;
      gpio_data_reg <= `PDM_GPIO_DATA_RST;
    end else begin
      pullup_reg <= pullup_next;
      periph_en_reg <= periph_en_next;
      periph_sel_reg <= periph_sel_next;
      bus_drive_reg <= bus_drive_next;
      dm_mode_reg <= dm_mode_next;
      gpio_dir_reg <= gpio_dir_next;
      gpio_data_reg <= gpio_data_next;
    end
  end

  // ----------------------------------------------------------------
  // chip select decode
  // ----------------------------------------------------------------
  logic one_hit, two_hit;
  pdm_pkg::pdm_func_e f9, f0;

  // chip select one follows data space while in legacy mode
  always_comb begin
    if (dm_mode_reg) begin
      one_hit = ext_mem_active_i & ext_mem_data_space_i;
    end else begin
      one_hit = ext_mem_active_i &
        (((ext_mem_addr_i ^ chip_select_one_base_i) & chip_select_one_mask_i) == '0);
    end
    two_hit = ext_mem_active_i &
      (((ext_mem_addr_i ^ chip_select_two_base_i) & chip_select_two_mask_i) == '0);
  end

  // owner of each pin
  always_comb begin
    f9 = periph_en_reg[`PDM_PIN_DMSEL] ? pdm_pkg::PDM_FN_CHIPSEL : pdm_pkg::PDM_FN_GPIO;
    if (!periph_en_reg[`PDM_PIN_CSTWO]) begin
      f0 = pdm_pkg::PDM_FN_GPIO;
    end else if (periph_sel_reg[`PDM_SEL_CAN_BIT]) begin
      f0 = pdm_pkg::PDM_FN_CAN;
    end else begin
      f0 = pdm_pkg::PDM_FN_CHIPSEL;
    end
  end

  // ----------------------------------------------------------------
  // pad drive per owner
  // ----------------------------------------------------------------
  logic en9, val9, en0, val0;

  // idle chip selects either float or hold high; floating relies on the pull-up
  always_comb begin
    case (f9)
      pdm_pkg::PDM_FN_CHIPSEL: begin
        en9 = ext_mem_active_i | bus_drive_reg;
        val9 = ~one_hit;
      end
      default: begin
        en9 = gpio_dir_reg[`PDM_PIN_DMSEL];
        val9 = gpio_data_reg[`PDM_PIN_DMSEL];
      end
    endcase
    case (f0)
      pdm_pkg::PDM_FN_CHIPSEL: begin
        en0 = ext_mem_active_i | bus_drive_reg;
        val0 = ~two_hit;
      end
      pdm_pkg::PDM_FN_CAN: begin
        en0 = ~second_can_transmit_i;
        val0 = 1'b0;
      end
      default: begin
        en0 = gpio_dir_reg[`PDM_PIN_CSTWO];
        val0 = gpio_data_reg[`PDM_PIN_CSTWO];
      end
    endcase
  end

  pdm_pin_cell u_pin9 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .drive_en_i(en9),
    .drive_val_i(val9),
    .pullup_en_i(pullup_reg[`PDM_PIN_DMSEL]),
    .pad_in_i(port_d_pin9_in_i),
    .pad_out_o(port_d_pin9_out_o),
    .pad_oe_n_o(port_d_pin9_oe_n_o),
    .pad_pullup_o(port_d_pin9_pullup_o),
    .pad_sync_o(port_d_gpio_in_o[1])
  );

  pdm_pin_cell u_pin0 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .drive_en_i(en0),
    .drive_val_i(val0),
    .pullup_en_i(pullup_reg[`PDM_PIN_CSTWO]),
    .pad_in_i(port_d_pin0_in_i),
    .pad_out_o(port_d_pin0_out_o),
    .pad_oe_n_o(port_d_pin0_oe_n_o),
    .pad_pullup_o(port_d_pin0_pullup_o),
    .pad_sync_o(port_d_gpio_in_o[0])
  );

  assign pin9_func_o = f9;
  assign pin0_func_o = f0;
  assign data_memory_select_mode_o = dm_mode_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_data_access;
    ext_mem_active_i && ext_mem_data_space_i && dm_mode_reg && periph_en_reg[9];
  endsequence

  sequence s_pin9_driven_low;
    !port_d_pin9_oe_n_o && !port_d_pin9_out_o;
  endsequence

  chk_data_select_low: assert property (s_data_access |=> s_pin9_driven_low)
    else $error("data memory select not low during data access");

  chk_reset_legacy_mode: assert property (disable iff (1'b0)
    !rst_n_i ##1 (rst_n_i && !$past(cfg_we_i)) |-> dm_mode_reg)
    else $error("chip select one not in data select mode after reset");

  chk_idle_release: assert property (!ext_mem_active_i && !bus_drive_reg &&
    f0 == pdm_pkg::PDM_FN_CHIPSEL |=> port_d_pin0_oe_n_o)
    else $error("idle chip select two still driven");

  chk_idle_hold_high: assert property (!ext_mem_active_i && bus_drive_reg &&
    f9 == pdm_pkg::PDM_FN_CHIPSEL |=> !port_d_pin9_oe_n_o && port_d_pin9_out_o)
    else $error("idle chip select not held high");

  chk_region_select: assert property (f0 == pdm_pkg::PDM_FN_CHIPSEL && ext_mem_active_i
    |=> !port_d_pin0_oe_n_o && (port_d_pin0_out_o == !$past(two_hit)))
    else $error("chip select two level wrong for address");

  chk_gpio_direction: assert property (f0 == pdm_pkg::PDM_FN_GPIO
    |=> port_d_pin0_oe_n_o == !$past(gpio_dir_reg[0]))
    else $error("gpio direction not followed");

  chk_pullup_pin9: assert property (##1 port_d_pin9_pullup_o == $past(pullup_reg[9]))
    else $error("pin9 pull-up not following enable bit");

  chk_pullup_pin0: assert property (!pullup_reg[0] |=> !port_d_pin0_pullup_o)
    else $error("pin0 pull-up not removed");

  chk_gpio_after_reset: assert property (disable iff (1'b0)
    !rst_n_i |=> !periph_en_reg[0] && f0 == pdm_pkg::PDM_FN_GPIO)
    else $error("pin0 not gpio after reset");

  chk_can_select: assert property (periph_en_reg[0] && periph_sel_reg[4]
    |=> port_d_pin0_oe_n_o == $past(second_can_transmit_i))
    else $error("select bit does not give can the pin");

  chk_can_open_drain: assert property (f0 == pdm_pkg::PDM_FN_CAN
    |=> port_d_pin0_oe_n_o || !port_d_pin0_out_o)
    else $error("can transmit drove the pin high");

endmodule : pdm_port_d_mux

// ===== pdm_pad_model.sv
/*
  Far-side pad model: resolves one shared pin from the mux drive, an
  outside driver and the internal pull-up.
  Assumes one instance per pad, clocked by the bench clock.
*/
`timescale 1ns/1ps

module pdm_pad_model (
  input wire logic clk_i,
  input wire logic out_i,
  input wire logic oe_n_i,
  input wire logic pullup_i,
  input wire logic ext_en_i,
  input wire logic ext_val_i,
  output logic pad_o
);
  logic float_reg = 1'b0;

  // a floating pad wanders, so a stale level never passes for a good one
  always @(posedge clk_i) float_reg <= ~float_reg;

  // mux drive first, then the far side, then the pull-up
  always_comb begin
    if (!oe_n_i) pad_o = out_i;
    else if (ext_en_i) pad_o = ext_val_i;
    else if (pullup_i) pad_o = 1'b1;
    else pad_o = float_reg;
  end
endmodule : pdm_pad_model

// ===== pdm_port_d_mux_tb.sv
/*
  Self-checking bench for the port D pin-function mux.
  Assumes the design files and the pad model are compiled before it.
*/
`timescale 1ns/1ps

module pdm_port_d_mux_tb;
  logic clk_i, rst_n_i, act, dsp, we, drv, mode, tx, e9, v9;
  logic [15:0] addr, b1, m1, b2, m2, pu, pe, ps, dir, dat;
  logic o9, n9, u9, o0, n0, u0, pad9, pad0;
  logic [1:0] gin;
  pdm_pkg::pdm_func_e f9, f0;
  logic mode_o;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  pdm_port_d_mux uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_mem_active_i(act),
    .ext_mem_data_space_i(dsp), .ext_mem_addr_i(addr), .chip_select_one_base_i(b1),
    .chip_select_one_mask_i(m1), .chip_select_two_base_i(b2),
    .chip_select_two_mask_i(m2), .cfg_we_i(we), .port_d_pullup_enable_i(pu),
    .port_d_peripheral_enable_i(pe), .peripheral_select_register_i(ps),
    .bus_drive_control_i(drv), .data_memory_select_mode_i(mode), .gpio_dir_i(dir),
    .gpio_data_i(dat), .second_can_transmit_i(tx), .port_d_pin9_in_i(pad9),
    .port_d_pin0_in_i(pad0), .port_d_pin9_out_o(o9), .port_d_pin9_oe_n_o(n9),
    .port_d_pin9_pullup_o(u9), .port_d_pin0_out_o(o0), .port_d_pin0_oe_n_o(n0),
    .port_d_pin0_pullup_o(u0), .port_d_gpio_in_o(gin), .pin9_func_o(f9),
    .pin0_func_o(f0), .data_memory_select_mode_o(mode_o));

  pdm_pad_model pad9_m (.clk_i(clk_i), .out_i(o9), .oe_n_i(n9), .pullup_i(u9),
    .ext_en_i(e9), .ext_val_i(v9), .pad_o(pad9));
  pdm_pad_model pad0_m (.clk_i(clk_i), .out_i(o0), .oe_n_i(n0), .pullup_i(u0),
    .ext_en_i(1'b0), .ext_val_i(1'b0), .pad_o(pad0));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // whole run is under 200 cycles; 2000 means a hang
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task end_of_test;
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task cmp(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  // settles at a falling edge, clear of the launching edge
  task step(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : step

  // config fields load together on one strobe; pads follow two edges on
  task cfg(input logic [15:0] u, e, s, d, v, input logic b, m);
    @(posedge clk_i);
    pu <= u; pe <= e; ps <= s; dir <= d; dat <= v; drv <= b; mode <= m; we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
    step(3);
  endtask : cfg

  task bus(input logic a, input logic s, input logic [15:0] ad);
    @(posedge clk_i);
    act <= a; dsp <= s; addr <= ad;
    step(3);
  endtask : bus

  task can_tx(input logic v);
    @(posedge clk_i);
    tx <= v;
    step(3);
  endtask : can_tx

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0; act = 1'b0; dsp = 1'b0; we = 1'b0; drv = 1'b0; mode = 1'b1;
    tx = 1'b1; e9 = 1'b0; v9 = 1'b0; addr = 16'h0000; b2 = 16'h8000; m2 = 16'hC000;
    pu = 16'hFFFF; pe = 16'h0200; ps = 16'h0000; dir = 16'h0000; dat = 16'h0000;
    b1 = 16'h0000; m1 = 16'h8000;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    step(3);
    cmp(mode_o, 1'h1);
    cmp(f9, pdm_pkg::PDM_FN_CHIPSEL);
    cmp(f0, pdm_pkg::PDM_FN_GPIO);
    cmp({n9, n0, u9, u0}, 4'hF);
    bus(1'h1, 1'h1, 16'h0010);
    cmp({n9, o9}, 2'h0);
    bus(1'h1, 1'h0, 16'h0010);
    cmp({n9, o9}, 2'h1);
    bus(1'h0, 1'h0, 16'h0000);
    cmp(n9, 1'h1);
    cfg(16'hFFFF, 16'h0201, 16'h0000, 16'h0000, 16'h0000, 1'h1, 1'h1);
    cmp({n9, o9, n0, o0}, 4'h5);
    cmp(f0, pdm_pkg::PDM_FN_CHIPSEL);
    bus(1'h1, 1'h0, 16'h8123);
    cmp({n0, o0}, 2'h0);
    bus(1'h1, 1'h0, 16'h4123);
    cmp({n0, o0}, 2'h1);
    // bus drive off: both idle chip selects float onto their pull-ups
    bus(1'h0, 1'h0, 16'h0000);
    cfg(16'hFFFF, 16'h0201, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h1);
    cmp({n9, n0, pad9, pad0}, 4'hF);
    // legacy mode off: chip select one decodes its own region (addr bit 15 low)
    cfg(16'hFFFF, 16'h0201, 16'h0000, 16'h0000, 16'h0000, 1'h1, 1'h0);
    bus(1'h1, 1'h1, 16'h8000);
    cmp({n9, o9}, 2'h1);
    bus(1'h1, 1'h0, 16'h0010);
    cmp({n9, o9}, 2'h0);
    cfg(16'hFFFF, 16'h0201, 16'h0010, 16'h0000, 16'h0000, 1'h1, 1'h0);
    cmp(f0, pdm_pkg::PDM_FN_CAN);
    cmp({n0, pad0}, 2'h3);
    can_tx(1'h0);
    cmp({n0, o0, pad0}, 3'h0);
    // a chip select two miss would drive high; can still holds the pin low
    bus(1'h1, 1'h0, 16'h4123);
    cmp({n0, o0}, 2'h0);
    can_tx(1'h1);
    cmp({n0, pad0}, 2'h3);
    bus(1'h0, 1'h0, 16'h0000);
    // second reset in mid-run, with pin0 on can and legacy mode off
    @(posedge clk_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'h1;
    step(2);
    cmp({f9, f0}, {pdm_pkg::PDM_FN_CHIPSEL, pdm_pkg::PDM_FN_GPIO});
    cmp({n9, n0, mode_o}, 3'h7);
    cfg(16'hFFFF, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 1'h0, 1'h1);
    cmp(f9, pdm_pkg::PDM_FN_GPIO);
    @(posedge clk_i);
    e9 <= 1'h1;
    step(3);
    cmp({n9, n0, o0, gin}, 5'h15);
    @(posedge clk_i);
    e9 <= 1'h0;
    cfg(16'hFFFF, 16'h0000, 16'h0000, 16'h0200, 16'h0000, 1'h0, 1'h1);
    cmp({n9, o9, n0, gin}, 5'h05);
    cfg(16'hFDFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h1);
    cmp({u9, u0, gin[0]}, 3'h3);
    cfg(16'hFFFE, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h1);
    cmp({u9, u0, gin[1]}, 3'h5);
    end_of_test();
  end
endmodule : pdm_port_d_mux_tb
